// ### logic/cpcs_clock_select.sv
`timescale 1ns/1ns
`default_nettype none
module cpcs_clock_select #(
  // Settling wait and oscillator pulse spacing, in clock cycles
  parameter int STAB_CYC = cpcs_pkg::STAB_CYCLES,
  parameter int OSC_DIV = cpcs_pkg::INT_OSC_DIV
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus
  input wire cpcs_pkg::cpcs_axi_req_t axi_req,
  output cpcs_pkg::cpcs_axi_rsp_t axi_rsp,
  // Clock sources as enable pulses
  input wire logic high_speed_sys_clk_tick,
  input wire logic sub_clk_tick,
  // Generated enables and status
  output cpcs_pkg::cpcs_clk_en_t clk_en,
  output logic int_osc_stable,
  output logic irq
);
  import cpcs_pkg::*;

  // Whole state of the block
  typedef struct packed {
    // Oscillator control and settling
    logic int_osc_stop;
    logic int_osc_stable;
    logic [15:0] stab_cnt;
    logic [7:0] osc_cnt;
    // Settings as last written by software
    logic sel_req;
    logic mode_req;
    logic [2:0] div_req;
    logic cpu_src_req;
    // Settings in force, moved over only at a CPU period boundary
    logic sel_act;
    logic mode_act;
    logic [2:0] div_act;
    logic cpu_src_act;
    // CPU divider count and registered enables
    logic [3:0] cpu_cnt;
    cpcs_clk_en_t en;
    // Interrupt status and mask
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] irq_mask;
    // Write channel halves, held until the write is done
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // Write response
    logic bvalid;
    logic [1:0] bresp;
    // Read response
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cpcs_state_t;

  // One register holds the whole state; the comb block builds its next value
  cpcs_state_t st; // Current state
  cpcs_state_t next_st; // Next state

  // Last count of the CPU divider for a code
  // Code n divides by two to the n, so the count runs from 0 to 2^n - 1;
  // only codes up to the maximum ever reach the active field
  function automatic logic [3:0] div_limit(input logic [2:0] code);
    logic [4:0] ratio;
    ratio = 5'h01 << code;
    div_limit = 4'(ratio - 5'h01);
  endfunction : div_limit

  // Mapped register check
  // Any other offset answers with an error; a write there changes nothing
  // and a read there returns zero
  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = (addr == OFS_OSC_CTRL) || (addr == OFS_CLK_MODE) || (addr == OFS_CPU_CTRL)
      || (addr == OFS_IRQ_STATUS) || (addr == OFS_IRQ_MASK);
  endfunction : reg_hit

  // Read view of the registers
  // Unused bits read as zero; requested and active settings sit side by side
  // so software can see when a change has taken effect
  function automatic logic [31:0] reg_read(input cpcs_state_t s, input logic [7:0] addr);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (addr)
      // Oscillator control: stop bit and stable flag
      OFS_OSC_CTRL: begin
        d[BIT_OSC_STOP] = s.int_osc_stop;
        d[BIT_OSC_STABLE] = s.int_osc_stable;
      end
      // Clock mode: requested and active select and mode
      OFS_CLK_MODE: begin
        d[BIT_MODE] = s.mode_req;
        d[BIT_SEL] = s.sel_req;
        d[BIT_MODE_ACT] = s.mode_act;
        d[BIT_SEL_ACT] = s.sel_act;
      end
      // CPU control: requested and active divider and source
      OFS_CPU_CTRL: begin
        d[DIV_LSB +: 3] = s.div_req;
        d[BIT_CPU_SRC] = s.cpu_src_req;
        d[DIV_ACT_LSB +: 3] = s.div_act;
        d[BIT_CPU_SRC_ACT] = s.cpu_src_act;
      end
      // Interrupt status and mask
      OFS_IRQ_STATUS: d[EVT_W-1:0] = s.irq_status;
      OFS_IRQ_MASK: d[EVT_W-1:0] = s.irq_mask;
      default: d = 32'h0000_0000;
    endcase
    reg_read = d;
  endfunction : reg_read

  // Per-cycle decode, all filled by the next-state logic
  logic osc_run; // Oscillator allowed to run
  logic osc_tick; // Internal oscillator pulse
  logic main_tick; // Main system clock pulse
  logic per_tick; // Peripheral clock pulse
  logic cpu_src_tick; // Pulse feeding the CPU divider
  logic cpu_fire; // CPU clock pulse
  logic boundary; // CPU period boundary, safe to switch
  logic [EVT_W-1:0] evt; // Events this cycle
  logic [EVT_W-1:0] clr; // Status bits cleared this cycle
  logic [2:0] wdiv; // Divider code being written

  // Handshake outputs straight from state
  // Ready stays low while a half is held or an answer waits, so at most one
  // write and one read are ever in flight
  always_comb begin
    axi_rsp.awready = !st.aw_got && !st.bvalid;
    axi_rsp.wready = !st.w_got && !st.bvalid;
    axi_rsp.bvalid = st.bvalid;
    axi_rsp.bresp = st.bresp;
    axi_rsp.arready = !st.rvalid;
    axi_rsp.rvalid = st.rvalid;
    axi_rsp.rdata = st.rdata;
    axi_rsp.rresp = st.rresp;
  end

  // Registered outputs
  // The interrupt is a level, high while any unmasked status bit is set
  assign clk_en = st.en;
  assign int_osc_stable = st.int_osc_stable;
  assign irq = |(st.irq_status & st.irq_mask);

  // Next-state logic
  always_comb begin
    next_st = st;
    // No event, no clear and no divider code unless a branch below sets one
    evt = '0;
    clr = '0;
    wdiv = 3'h0;
    // Stop takes effect only while the main clock comes from the high-speed
    // system clock; stopping the oscillator while it feeds the main clock
    // would freeze the CPU with nothing left to restart it
    osc_run = !(st.int_osc_stop && st.sel_act && st.mode_act);
    // One oscillator pulse every OSC_DIV cycles while it runs
    osc_tick = osc_run && (st.osc_cnt == 8'(OSC_DIV - 1));
    if (!osc_run) begin
      // Stopped: restart accuracy wait from scratch
      // Stable drops at once, so software never reads a stale flag
      next_st.osc_cnt = 8'h00;
      next_st.stab_cnt = 16'h0000;
      next_st.int_osc_stable = 1'b0;
    end else begin
      // Running: divide and time the settling
      // Stable rises once after the settling count and holds until a stop
      next_st.osc_cnt = osc_tick ? 8'h00 : st.osc_cnt + 8'h01;
      if (st.stab_cnt != 16'(STAB_CYC)) begin
        next_st.stab_cnt = st.stab_cnt + 16'h0001;
      end else if (!st.int_osc_stable) begin
        next_st.int_osc_stable = 1'b1;
        evt[EVT_STABLE] = 1'b1;
      end
    end

    // Source selection from the active bits
    // Select and mode both set take the main clock from the high-speed clock;
    // select alone moves only the peripheral clock over
    main_tick = (st.sel_act && st.mode_act) ? high_speed_sys_clk_tick : osc_tick;
    per_tick = st.sel_act ? high_speed_sys_clk_tick : osc_tick;
    cpu_src_tick = st.cpu_src_act ? sub_clk_tick : main_tick;
    // The CPU fires on the source pulse that completes its period
    cpu_fire = cpu_src_tick && (st.cpu_cnt == div_limit(st.div_act));
    if (cpu_src_tick) begin
      // Count source pulses within one CPU period
      next_st.cpu_cnt = cpu_fire ? 4'h0 : st.cpu_cnt + 4'h1;
    end
    // Enables are registered, so each output pulse lasts exactly one cycle
    next_st.en.main_en = main_tick;
    next_st.en.per_en = per_tick;
    next_st.en.cpu_en = cpu_fire;

    // Apply pending choices only between whole CPU periods
    // A boundary is a cycle with the count at zero and no partial period
    // begun, so a change of source or ratio leaves no short pulse behind.
    // A source that stops mid-period, with the count above zero, holds the change back for good.
    boundary = (st.cpu_cnt == 4'h0) && (!cpu_src_tick || cpu_fire);
    // Only a real change raises the switch event
    if (boundary && ({st.sel_req, st.mode_req, st.div_req, st.cpu_src_req}
        != {st.sel_act, st.mode_act, st.div_act, st.cpu_src_act})) begin
      next_st.sel_act = st.sel_req;
      next_st.mode_act = st.mode_req;
      next_st.div_act = st.div_req;
      next_st.cpu_src_act = st.cpu_src_req;
      next_st.cpu_cnt = 4'h0;
      evt[EVT_SWITCH] = 1'b1;
    end

    // Write address and data, taken in either order
    // Each half is latched on its own handshake, which drops its ready
    // until the write has been answered
    if (axi_req.awvalid && axi_rsp.awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      next_st.w_got = 1'b1;
      next_st.w_data = axi_req.wdata;
      next_st.w_strb = axi_req.wstrb;
    end

    // Perform the write once both halves are held
    // The write lands one cycle after the later half; every field sits in
    // byte lane 0, so the other lanes are ignored
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = reg_hit(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      wdiv = st.w_data[DIV_LSB +: 3];
      if (st.w_strb[0]) begin
        // Only the addressed register changes, except the status flag that a forbidden divider code sets
        case (st.aw_addr)
          OFS_OSC_CTRL: next_st.int_osc_stop = st.w_data[BIT_OSC_STOP];
          OFS_CLK_MODE: begin
            next_st.mode_req = st.w_data[BIT_MODE];
            next_st.sel_req = st.w_data[BIT_SEL];
          end
          OFS_CPU_CTRL: begin
            next_st.cpu_src_req = st.w_data[BIT_CPU_SRC];
            if (wdiv <= DIV_MAX) begin
              next_st.div_req = wdiv;
            end else begin
              // Forbidden code: keep the old ratio and flag it
              // The write is still answered OKAY
              evt[EVT_BAD_DIV] = 1'b1;
            end
          end
          OFS_IRQ_STATUS: clr = st.w_data[EVT_W-1:0];
          OFS_IRQ_MASK: next_st.irq_mask = st.w_data[EVT_W-1:0];
          default: clr = '0;
        endcase
      end
    end
    // Write response leaves on bready
    // The answer stands until the master takes it
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end

    // Read: one request at a time, data from flops
    // Read data comes from the registered state, so a write in the same
    // cycle shows up only on the next read
    if (axi_req.arvalid && axi_rsp.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = reg_read(st, axi_req.araddr);
      next_st.rresp = reg_hit(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end

    // Sticky events, a new event beats a clear
    // Cleared by writing a one; an event in the clearing cycle stays set
    next_st.irq_status = (st.irq_status & ~clr) | evt;
  end

  // State register
  // Synchronous reset: oscillator running and feeding main, peripheral and
  // CPU clocks, CPU divided by two, bus idle
  // Requested and active settings start equal, so no switch event follows
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
      st.int_osc_stop <= RST_OSC_STOP;
      st.sel_req <= RST_SEL;
      st.mode_req <= RST_MODE;
      st.div_req <= RST_DIV;
      st.cpu_src_req <= RST_CPU_SRC;
      st.sel_act <= RST_SEL;
      st.mode_act <= RST_MODE;
      st.div_act <= RST_DIV;
      st.cpu_src_act <= RST_CPU_SRC;
      st.bresp <= RESP_OKAY;
      st.rresp <= RESP_OKAY;
    end else begin
      st <= next_st;
    end
  end
endmodule : cpcs_clock_select
`default_nettype wire

// ### logic/cpcs_pkg.sv
// Notes on behaviour
// - Clearing stop bit restarts internal oscillator
// - Stable bit rises once accuracy reached
// - Reset starts oscillator, selects it for CPU
// - Select/mode bits choose main, peripheral source
// - CPU source zero feeds divided main clock
// - Divider codes 0-4 give 1 to 16
`default_nettype none
package cpcs_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFS_CLK_MODE = 8'h04;
  localparam logic [7:0] OFS_CPU_CTRL = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // Field positions
  localparam int BIT_OSC_STOP = 0;
  localparam int BIT_OSC_STABLE = 1;
  localparam int BIT_MODE = 0;
  localparam int BIT_SEL = 1;
  localparam int BIT_MODE_ACT = 4;
  localparam int BIT_SEL_ACT = 5;
  localparam int DIV_LSB = 0;
  localparam int BIT_CPU_SRC = 4;
  localparam int DIV_ACT_LSB = 8;
  localparam int BIT_CPU_SRC_ACT = 12;
  localparam int EVT_STABLE = 0;
  localparam int EVT_SWITCH = 1;
  localparam int EVT_BAD_DIV = 2;
  localparam int EVT_W = 3;
  // Reset values and largest allowed divider code
  localparam logic RST_OSC_STOP = 1'b0;
  localparam logic RST_SEL = 1'b0;
  localparam logic RST_MODE = 1'b0;
  localparam logic [2:0] RST_DIV = 3'h1;
  localparam logic RST_CPU_SRC = 1'b0;
  localparam logic [2:0] DIV_MAX = 3'h4;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int STAB_TIME_NS = 1000;
  localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_OSC_DIV = 2;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } cpcs_axi_req_t;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cpcs_axi_rsp_t;

  // Clock enable pulses
  typedef struct packed {
    logic main_en;
    logic per_en;
    logic cpu_en;
  } cpcs_clk_en_t;
endpackage : cpcs_pkg
`default_nettype wire

// ### verification/cpcs_clock_select_checker.sv
`timescale 1ns/1ns
`default_nettype none
module cpcs_clock_select_checker #(
  parameter int STAB_CYC = cpcs_pkg::STAB_CYCLES,
  parameter int OSC_DIV = cpcs_pkg::INT_OSC_DIV
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus
  input wire cpcs_pkg::cpcs_axi_req_t axi_req,
  input wire cpcs_pkg::cpcs_axi_rsp_t axi_rsp,
  // Sources and outputs
  input wire logic high_speed_sys_clk_tick,
  input wire logic sub_clk_tick,
  input wire cpcs_pkg::cpcs_clk_en_t clk_en,
  input wire logic int_osc_stable,
  input wire logic irq
);
  import cpcs_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Everything quiet right after release
  reset_quiet_a: assert property ($fell(rst) |-> clk_en == '0 && !int_osc_stable && !irq)
    else $error("outputs active after reset");
  // Stable only after a settling wait, but within a bound
  stable_wait_a: assert property ($fell(rst) |-> !int_osc_stable [*4] ##[1:300] int_osc_stable)
    else $error("stable flag timing wrong");
  // CPU pulse comes from main clock or alternate source
  cpu_source_a: assert property (clk_en.cpu_en |-> clk_en.main_en || $past(sub_clk_tick))
    else $error("cpu pulse without source");
  // Sources never pulse twice in a row, so neither may the CPU
  no_glitch_a: assert property (clk_en.cpu_en |=> !clk_en.cpu_en)
    else $error("cpu pulse stretched");
  // Peripheral pulse follows high-speed tick or oscillator
  per_source_a: assert property (clk_en.per_en |-> $past(high_speed_sys_clk_tick) || clk_en.main_en)
    else $error("peripheral pulse without source");
  // Read answered in the next cycle
  read_latency_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  // Write answered two edges after both halves taken
  write_latency_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##2 axi_rsp.bvalid)
    else $error("write answer late");
  // No new read while one is answered
  read_refuse_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read accepted while busy");
  cover property (clk_en.cpu_en);
  cover property ($rose(irq));
  cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR);
endmodule : cpcs_clock_select_checker
bind cpcs_clock_select cpcs_clock_select_checker #(.STAB_CYC(STAB_CYC), .OSC_DIV(OSC_DIV)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .high_speed_sys_clk_tick(high_speed_sys_clk_tick), .sub_clk_tick(sub_clk_tick),
  .clk_en(clk_en), .int_osc_stable(int_osc_stable), .irq(irq));
`default_nettype wire

// ### verification/tb_cpu_peripheral_clock_select.sv
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_peripheral_clock_select;
  import cpcs_pkg::*;
  logic ref_clk;
  logic rst;
  cpcs_axi_req_t req;
  cpcs_axi_rsp_t rsp;
  logic hs_tick;
  logic sub_tick;
  cpcs_clk_en_t en;
  logic stable;
  logic irq;
  logic [31:0] seed;
  logic [31:0] d;
  logic [1:0] r;
  int err_count;
  int n_tests;
  // Short settling count keeps the run brief
  cpcs_clock_select #(.STAB_CYC(4)) u_cpcs_clock_select (.ref_clk(ref_clk), .rst(rst), .axi_req(req),
    .axi_rsp(rsp), .high_speed_sys_clk_tick(hs_tick), .sub_clk_tick(sub_tick), .clk_en(en),
    .int_osc_stable(stable), .irq(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Random source pulses, never two in a row; the high-speed clock runs
  // from the start, well before software selects it
  always @(posedge ref_clk) begin
    seed <= lfsr(seed);
    hs_tick <= !hs_tick && seed[0];
    sub_tick <= !sub_tick && seed[3];
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  // Write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
      if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    r = rsp.bresp;
  endtask : wr
  task automatic bus_rd(input logic [7:0] a);
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    d = rsp.rdata;
    r = rsp.rresp;
  endtask : bus_rd
  // Read until masked field matches, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do begin
      bus_rd(a);
      k++;
    end while ((d & m) !== v && k < 100);
    check(d & m, v);
  endtask : poll
  // Main pulses per CPU pulse must equal the divide ratio
  task automatic ratio(input logic [2:0] c);
    logic [31:0] n;
    int k;
    n = 0;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (!en.cpu_en && k < 500);
    do begin
      @(posedge ref_clk);
      n = n + 32'(en.main_en);
      k++;
    end while (!en.cpu_en && k < 1000);
    check(n, 32'h1 << c);
  endtask : ratio
  // Peripheral pulse follows the tick (hs) or the main pulse
  task automatic per_chk(input logic hs);
    logic p;
    @(posedge ref_clk);
    p = hs_tick;
    repeat (40) begin
      @(posedge ref_clk);
      check(32'(en.per_en), 32'(hs ? p : en.main_en));
      p = hs_tick;
    end
  endtask : per_chk
  // CPU pulse follows the alternate tick when that source is chosen
  task automatic sub_chk();
    logic p;
    @(posedge ref_clk);
    p = sub_tick;
    repeat (40) begin
      @(posedge ref_clk);
      check(32'(en.cpu_en), 32'(p));
      p = sub_tick;
    end
  endtask : sub_chk
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
  initial begin
    req = '0;
    rst = 1'b1;
    hs_tick = 1'b0;
    sub_tick = 1'b0;
    seed = 32'hb0660b87;
    err_count = 0;
    n_tests = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    bus_rd(OFS_CPU_CTRL);
    check(d, 32'h101);
    poll(OFS_OSC_CTRL, 32'h3, 32'h2);
    poll(OFS_IRQ_STATUS, 32'h1, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    @(posedge ref_clk);
    check(32'(irq), 32'h1);
    wr(OFS_IRQ_STATUS, 32'h7);
    @(posedge ref_clk);
    check(32'(irq), 32'h0);
    for (int c = 0; c <= 4; c++) begin
      wr(OFS_CPU_CTRL, 32'(c));
      poll(OFS_CPU_CTRL, 32'h1700, 32'(c) << 8);
      ratio(3'(c));
    end
    // Forbidden code is refused and flagged
    wr(OFS_CPU_CTRL, 32'h5 + (seed % 3));
    bus_rd(OFS_CPU_CTRL);
    check(d & 32'h7, 32'h4);
    poll(OFS_IRQ_STATUS, 32'h4, 32'h4);
    wr(OFS_CLK_MODE, 32'h2);
    poll(OFS_CLK_MODE, 32'h30, 32'h20);
    per_chk(1'b1);
    wr(OFS_CLK_MODE, 32'h0);
    poll(OFS_CLK_MODE, 32'h30, 32'h0);
    per_chk(1'b0);
    // Main from high-speed clock, then stop and restart oscillator
    wr(OFS_CLK_MODE, 32'h3);
    poll(OFS_CLK_MODE, 32'h30, 32'h30);
    wr(OFS_OSC_CTRL, 32'h1);
    bus_rd(OFS_OSC_CTRL);
    check(d, 32'h1);
    wr(OFS_OSC_CTRL, 32'h0);
    poll(OFS_OSC_CTRL, 32'h3, 32'h2);
    // Alternate CPU source, undivided
    wr(OFS_CPU_CTRL, 32'h10);
    poll(OFS_CPU_CTRL, 32'h1700, 32'h1000);
    sub_chk();
    // Unmapped place answers with an error
    bus_rd(8'h20);
    check(d, 32'h0);
    check(32'(r), 32'(RESP_SLVERR));
    wr(8'h20, seed);
    check(32'(r), 32'(RESP_SLVERR));
    conclude();
  end
endmodule : tb_cpu_peripheral_clock_select
`default_nettype wire
